//--- hdl/exec_core.sv
// Notes on behaviour
// - Copy register 0-127 to work or itself
// - Copy sets only zero flag, one cycle
// - No-operation only advances program counter
// - Literal exit loads work, pops, enables interrupts
// - Every exit pops top, level drops one
// - Interrupt exit pops, enables interrupts, two cycles
// - Call exit pops, keeps flags, two cycles
// - Rotate left through carry, carry only
// - Rotate right through carry, carry only
// - Rotate destination bit picks work or register
//
// The register addresses and the strobed register port were left to the implementer.
module exec_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Instruction port
    input wire logic instr_valid,
    input wire logic [exec_pkg::INSTR_W-1:0] instr,
    output logic instr_ready,
    output logic done,
    output logic illegal,
    // File register port
    input wire logic [exec_pkg::DATA_W-1:0] file_rdata,
    output logic [exec_pkg::REG_ADDR_W-1:0] file_addr,
    output logic [exec_pkg::DATA_W-1:0] file_wdata,
    output logic file_we,
    // Stack push from call logic
    input wire logic stack_push,
    input wire logic [exec_pkg::PC_W-1:0] stack_push_addr,
    // Core state
    output logic [exec_pkg::PC_W-1:0] pc,
    output logic [exec_pkg::DATA_W-1:0] working_register,
    output logic zero_flag,
    output logic carry_flag,
    output logic global_interrupt_enable,
    // Register port
    input wire logic [exec_pkg::BUS_AW-1:0] bus_addr,
    input wire logic [exec_pkg::BUS_DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [exec_pkg::BUS_DW-1:0] bus_rdata
);
    import exec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    exec_state_t state_r;
    exec_state_t state_nxt;
    logic run_r;
    logic run_nxt;
    logic ready_r;
    logic done_r;
    logic illegal_r;
    logic [PC_W-1:0] pc_r;
    logic [DATA_W-1:0] work_r;
    logic zero_r;
    logic carry_r;
    logic gie_r;
    logic [5:0] exit_op_r;
    logic [DATA_W-1:0] exit_lit_r;
    logic [REG_ADDR_W-1:0] file_addr_r;
    logic [DATA_W-1:0] file_wdata_r;
    logic file_we_r;
    logic [BUS_DW-1:0] rdata_r;

    logic take;
    logic [5:0] opc;
    logic dsel;
    logic [REG_ADDR_W-1:0] reg_sel;
    logic [DATA_W-1:0] lit;
    logic is_exit;
    logic is_fileop;
    logic is_known;
    logic [DATA_W-1:0] result;
    logic pop;
    logic [PC_W-1:0] stack_top;
    logic [LVL_W-1:0] stack_level;
    logic wr_ctrl;
    logic wr_flags;
    logic wr_work;
    logic wr_pc;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    assign take = instr_valid && ready_r;
    assign opc = instr[OPC_HI:OPC_LO];
    assign dsel = instr[DSEL_BIT];
    assign reg_sel = instr[REG_HI:0];
    assign lit = instr[LIT_HI:0];
    assign is_exit = (opc == OP_LIT_EXIT) || (opc == OP_INT_EXIT) || (opc == OP_CALL_EXIT);
    assign is_fileop = (opc == OP_COPY) || (opc == OP_ROTL) || (opc == OP_ROTR);
    assign is_known = is_exit || is_fileop || (opc == OP_NOP);
    assign pop = (state_r == ST_EXIT);

    assign wr_ctrl = bus_wr && (bus_addr == OFF_CTRL);
    assign wr_flags = bus_wr && (bus_addr == OFF_FLAGS);
    assign wr_work = bus_wr && (bus_addr == OFF_WORK);
    assign wr_pc = bus_wr && (bus_addr == OFF_PC);

    always_comb begin
        case (opc)
            OP_ROTL: result = {file_rdata[6:0], carry_r};
            OP_ROTR: result = {carry_r, file_rdata[7:1]};
            default: result = file_rdata;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing: exits hold the port one extra cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take && is_exit) begin
                    state_nxt = ST_EXIT;
                end
            end
            ST_EXIT: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        run_nxt = wr_ctrl ? bus_wdata[CTRL_RUN_BIT] : run_r;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            run_r <= RST_RUN;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            run_r <= run_nxt;
            ready_r <= run_nxt && (state_nxt == ST_IDLE);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            exit_op_r <= OP_NOP;
            exit_lit_r <= RST_WORK;
        end else if (take && is_exit) begin
            exit_op_r <= opc;
            exit_lit_r <= lit;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            done_r <= (take && !is_exit) || (state_r == ST_EXIT);
            illegal_r <= take && !is_known;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter: instruction effects win over software writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc_r <= RST_PC;
        end else if (state_r == ST_EXIT) begin
            pc_r <= stack_top;
        end else if (take && !is_exit) begin
            pc_r <= pc_r + 1'b1;
        end else if (wr_pc) begin
            pc_r <= bus_wdata[PC_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            work_r <= RST_WORK;
        end else if (state_r == ST_EXIT && exit_op_r == OP_LIT_EXIT) begin
            work_r <= exit_lit_r;
        end else if (take && is_fileop && !dsel) begin
            work_r <= result;
        end else if (wr_work) begin
            work_r <= bus_wdata[DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // File register write back
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            file_we_r <= 1'b0;
            file_addr_r <= '0;
            file_wdata_r <= '0;
        end else begin
            file_we_r <= take && is_fileop && dsel;
            if (take && is_fileop) begin
                file_addr_r <= reg_sel;
                file_wdata_r <= result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            zero_r <= RST_ZERO;
        end else if (take && opc == OP_COPY) begin
            zero_r <= (result == 8'h00);
        end else if (wr_flags) begin
            zero_r <= bus_wdata[FLAG_Z_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            carry_r <= RST_CARRY;
        end else if (take && opc == OP_ROTL) begin
            carry_r <= file_rdata[7];
        end else if (take && opc == OP_ROTR) begin
            carry_r <= file_rdata[0];
        end else if (wr_flags) begin
            carry_r <= bus_wdata[FLAG_C_BIT];
        end
    end

    // Set by an exit wins over a software clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gie_r <= RST_GIE;
        end else if (state_r == ST_EXIT && exit_op_r != OP_CALL_EXIT) begin
            gie_r <= 1'b1;
        end else if (wr_ctrl) begin
            gie_r <= bus_wdata[CTRL_GIE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack
    call_stack u_stack (
        .core_clk(core_clk),
        .rst(rst),
        .push(stack_push),
        .push_addr(stack_push_addr),
        .pop(pop),
        .top_addr(stack_top),
        .level(stack_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register port read, data valid only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (bus_rd) begin
            if (bus_addr == OFF_CTRL) begin
                rdata_r <= BUS_DW'({gie_r, run_r});
            end else if (bus_addr == OFF_FLAGS) begin
                rdata_r <= BUS_DW'({zero_r, carry_r});
            end else if (bus_addr == OFF_WORK) begin
                rdata_r <= BUS_DW'(work_r);
            end else if (bus_addr == OFF_PC) begin
                rdata_r <= BUS_DW'(pc_r);
            end else if (bus_addr == OFF_STACK) begin
                rdata_r <= BUS_DW'(stack_level);
            end else begin
                rdata_r <= '0;
            end
        end else begin
            rdata_r <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign instr_ready = ready_r;
    assign done = done_r;
    assign illegal = illegal_r;
    assign pc = pc_r;
    assign working_register = work_r;
    assign zero_flag = zero_r;
    assign carry_flag = carry_r;
    assign global_interrupt_enable = gie_r;
    assign file_addr = file_addr_r;
    assign file_wdata = file_wdata_r;
    assign file_we = file_we_r;
    assign bus_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks; flags assume no software write while an instruction runs
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_copy_to_work: assert property (take && opc == OP_COPY && !dsel |=>
        work_r == $past(file_rdata) && !file_we_r) else $error("copy to work wrong");

    a_copy_zero_only: assert property (take && opc == OP_COPY |=>
        zero_r == ($past(file_rdata) == 8'h00) && carry_r == $past(carry_r) && done_r)
        else $error("copy flag or timing wrong");

    a_noop_pc_only: assert property (take && opc == OP_NOP |=>
        pc_r == $past(pc_r) + 11'h001 && $stable(work_r) && $stable(carry_r) && $stable(zero_r)
        && !file_we_r) else $error("no-operation changed state");

    a_lit_exit_load: assert property (take && opc == OP_LIT_EXIT |-> ##2
        work_r == $past(lit, 2) && gie_r) else $error("literal exit wrong");

    a_exit_pops_level: assert property (take && is_exit && !stack_push |-> ##2
        stack_level == $past(stack_level, 2) - 3'h1 && pc_r == $past(stack_top, 1))
        else $error("exit pop wrong");

    a_int_exit_gie: assert property (take && opc == OP_INT_EXIT |-> ##2
        gie_r && zero_r == $past(zero_r, 2) && carry_r == $past(carry_r, 2))
        else $error("interrupt exit wrong");

    a_call_exit_keeps: assert property (take && opc == OP_CALL_EXIT && !wr_ctrl |-> ##2
        gie_r == $past(gie_r, 2) && zero_r == $past(zero_r, 2)) else $error("call exit changed state");

    a_rotl_result: assert property (take && opc == OP_ROTL |=>
        carry_r == $past(file_rdata[7]) && file_wdata_r == {$past(file_rdata[6:0]), $past(carry_r)}
        && zero_r == $past(zero_r)) else $error("rotate left wrong");

    a_rotr_result: assert property (take && opc == OP_ROTR |=>
        carry_r == $past(file_rdata[0]) && file_wdata_r == {$past(carry_r), $past(file_rdata[7:1])}
        && zero_r == $past(zero_r)) else $error("rotate right wrong");

    a_rot_route: assert property (take && (opc == OP_ROTL || opc == OP_ROTR) && dsel |=>
        file_we_r && file_addr_r == $past(reg_sel) && $stable(work_r)) else $error("rotate route wrong");

    a_exit_two_cycles: assert property (take && is_exit |=>
        !ready_r && !done_r ##1 done_r) else $error("exit not two cycles");

    c_copy_back: cover property (take && opc == OP_COPY && dsel);
    c_lit_exit: cover property (take && opc == OP_LIT_EXIT ##2 done_r);
    c_rot_pair: cover property (take && opc == OP_ROTL ##1 take && opc == OP_ROTR);
    c_int_exit: cover property (take && opc == OP_INT_EXIT);

endmodule // exec_core

//--- include/exec_pkg.sv
package exec_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int PC_W = 11;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int REG_ADDR_W = 7;
    localparam int STACK_DEPTH = 8;
    localparam int LVL_W = 3;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 16;

    ////////////////////////////////////////////////////////////////////////
    // Instruction word fields
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 8;
    localparam int DSEL_BIT = 7;
    localparam int REG_HI = 6;
    localparam int LIT_HI = 7;

    localparam logic [5:0] OP_NOP = 6'h00;
    localparam logic [5:0] OP_COPY = 6'h01;
    localparam logic [5:0] OP_ROTL = 6'h02;
    localparam logic [5:0] OP_ROTR = 6'h03;
    localparam logic [5:0] OP_LIT_EXIT = 6'h04;
    localparam logic [5:0] OP_INT_EXIT = 6'h05;
    localparam logic [5:0] OP_CALL_EXIT = 6'h06;

    ////////////////////////////////////////////////////////////////////////
    // Register port map
    localparam logic [BUS_AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [BUS_AW-1:0] OFF_FLAGS = 8'h04;
    localparam logic [BUS_AW-1:0] OFF_WORK = 8'h08;
    localparam logic [BUS_AW-1:0] OFF_PC = 8'h0C;
    localparam logic [BUS_AW-1:0] OFF_STACK = 8'h10;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_GIE_BIT = 1;
    localparam int FLAG_C_BIT = 0;
    localparam int FLAG_Z_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic RST_RUN = 1'b1;
    localparam logic RST_GIE = 1'b0;
    localparam logic RST_CARRY = 1'b0;
    localparam logic RST_ZERO = 1'b0;
    localparam logic [DATA_W-1:0] RST_WORK = 8'h00;
    localparam logic [PC_W-1:0] RST_PC = 11'h000;
    localparam logic [PC_W-1:0] RST_STACK_ENTRY = 11'h000;

    ////////////////////////////////////////////////////////////////////////
    // Execution states
    typedef enum logic {ST_IDLE, ST_EXIT} exec_state_t;

endpackage

//--- hdl/call_stack.sv
module call_stack (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Push side
    input wire logic push,
    input wire logic [exec_pkg::PC_W-1:0] push_addr,
    // Pop side
    input wire logic pop,
    output logic [exec_pkg::PC_W-1:0] top_addr,
    output logic [exec_pkg::LVL_W-1:0] level
);
    import exec_pkg::*;

    logic [PC_W-1:0] entry_mem [STACK_DEPTH];
    logic [LVL_W-1:0] level_r;
    logic [LVL_W-1:0] top_idx;

    // Circular: overflow overwrites the oldest entry, underflow wraps
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_r <= '0;
        end else if (pop) begin
            level_r <= level_r - 1'b1;
        end else if (push) begin
            level_r <= level_r + 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_entry
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    entry_mem[gi] <= RST_STACK_ENTRY;
                end else if (push && !pop && level_r == LVL_W'(gi)) begin
                    entry_mem[gi] <= push_addr;
                end
            end
        end
    endgenerate

    assign top_idx = level_r - 1'b1;
    assign top_addr = entry_mem[top_idx];
    assign level = level_r;

endmodule // call_stack

//--- bench/move_return_rotate_exec_tb.sv
module move_return_rotate_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import exec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr = '0;
    logic [DATA_W-1:0] file_rdata = '0;
    logic stack_push = 1'b0;
    logic [PC_W-1:0] stack_push_addr = '0;
    logic [BUS_AW-1:0] bus_addr = '0;
    logic [BUS_DW-1:0] bus_wdata = '0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic instr_ready, done, illegal, file_we, zero_flag, carry_flag, global_interrupt_enable;
    logic [REG_ADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] file_wdata, working_register;
    logic [PC_W-1:0] pc;
    logic [BUS_DW-1:0] bus_rdata, rd;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [PC_W-1:0] e_pc;
    logic [DATA_W-1:0] e_w;
    logic e_z, e_c, e_g;

    exec_core dut_u (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .done(done), .illegal(illegal), .file_rdata(file_rdata),
        .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we), .stack_push(stack_push),
        .stack_push_addr(stack_push_addr), .pc(pc), .working_register(working_register),
        .zero_flag(zero_flag), .carry_flag(carry_flag), .global_interrupt_enable(global_interrupt_enable),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_core();
        chk(16'(pc), 16'(e_pc));
        chk(16'(working_register), 16'(e_w));
        chk(16'(zero_flag), 16'(e_z));
        chk(16'(carry_flag), 16'(e_c));
        chk(16'(global_interrupt_enable), 16'(e_g));
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic push(input logic [10:0] a);
        @(posedge core_clk);
        stack_push <= 1'b1;
        stack_push_addr <= a;
        @(posedge core_clk);
        stack_push <= 1'b0;
    endtask

    // Exits also check the dead cycle between take and completion
    task automatic issue(input logic [5:0] op, input logic [7:0] lo, input logic [7:0] v, input bit ex);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr <= {op, lo};
        file_rdata <= v;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        file_rdata <= ~v;
        #1;
        if (ex) begin
            chk(16'(instr_ready), 16'h0000);
            chk(16'(pc), 16'(e_pc));
            @(posedge core_clk);
            #1;
        end
        chk(16'(done), 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        e_pc = 11'h000; e_w = 8'h00; e_z = 1'b0; e_c = 1'b0; e_g = 1'b0;
        chk_core();
        bus_read(OFF_CTRL, rd);
        chk(rd, 16'h0001);
        bus_read(8'h14, rd);
        chk(rd, 16'h0000);
        bus_read(OFF_STACK, rd);
        chk(rd, 16'h0000);
    endtask

    task automatic t_copy();
        bus_write(OFF_WORK, 16'h00AA);
        bus_write(OFF_FLAGS, 16'h0001);
        e_w = 8'hAA; e_c = 1'b1;
        issue(OP_COPY, 8'h00, 8'h00, 1'b0);
        e_pc++; e_w = 8'h00; e_z = 1'b1;
        chk_core();
        chk(16'(file_we), 16'h0000);
        issue(OP_COPY, 8'hFF, 8'h5A, 1'b0);
        e_pc++; e_z = 1'b0;
        chk_core();
        chk({file_we, file_addr, file_wdata}, 16'hFF5A);
    endtask

    task automatic t_nop();
        bus_write(OFF_PC, 16'h07FE);
        e_pc = 11'h7FE;
        issue(OP_NOP, 8'h00, 8'h33, 1'b0);
        e_pc++;
        chk_core();
        chk(16'(file_we), 16'h0000);
        issue(6'h3F, 8'h00, 8'h33, 1'b0);
        e_pc++;
        chk(16'(illegal), 16'h0001);
        chk_core();
    endtask

    // Zero set beforehand must survive all rotates
    task automatic t_rot();
        bus_write(OFF_FLAGS, 16'h0002);
        e_z = 1'b1; e_c = 1'b0;
        issue(OP_ROTL, 8'h91, 8'hA5, 1'b0);
        e_pc++; e_c = 1'b1;
        chk_core();
        chk({file_we, file_addr, file_wdata}, 16'h914A);
        issue(OP_ROTL, 8'h22, 8'h01, 1'b0);
        e_pc++; e_c = 1'b0; e_w = 8'h03;
        chk_core();
        chk(16'(file_we), 16'h0000);
        issue(OP_ROTR, 8'hB3, 8'hA5, 1'b0);
        e_pc++; e_c = 1'b1;
        chk_core();
        chk({file_we, file_addr, file_wdata}, 16'hB352);
        issue(OP_ROTR, 8'h44, 8'h02, 1'b0);
        e_pc++; e_c = 1'b0; e_w = 8'h81;
        chk_core();
        chk(16'(file_we), 16'h0000);
    endtask

    task automatic t_exits();
        bus_write(OFF_FLAGS, 16'h0003);
        e_z = 1'b1; e_c = 1'b1;
        push(11'h123);
        push(11'h456);
        push(11'h7FF);
        bus_read(OFF_STACK, rd);
        chk(rd, 16'h0003);
        issue(OP_CALL_EXIT, 8'h00, 8'h00, 1'b1);
        e_pc = 11'h7FF;
        chk_core();
        bus_read(OFF_STACK, rd);
        chk(rd, 16'h0002);
        issue(OP_INT_EXIT, 8'h00, 8'h00, 1'b1);
        e_pc = 11'h456; e_g = 1'b1;
        chk_core();
        bus_read(OFF_STACK, rd);
        chk(rd, 16'h0001);
        bus_write(OFF_CTRL, 16'h0001);
        e_g = 1'b0;
        issue(OP_LIT_EXIT, 8'h55, 8'h00, 1'b1);
        e_pc = 11'h123; e_g = 1'b1; e_w = 8'h55;
        chk_core();
        bus_read(OFF_STACK, rd);
        chk(rd, 16'h0000);
    endtask

    // Cleared run bit must hold off new instructions
    task automatic t_halt();
        bus_write(OFF_CTRL, 16'h0000);
        #1;
        chk(16'(instr_ready), 16'h0000);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr <= {OP_NOP, 8'h00};
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
        chk(16'(pc), 16'(e_pc));
        chk(16'(done), 16'h0000);
        bus_write(OFF_CTRL, 16'h0003);
        @(posedge core_clk);
        #1;
        chk(16'(instr_ready), 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run needs under a hundred cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_copy();
        t_nop();
        t_rot();
        t_exits();
        t_halt();
        complete_run();
    end
endmodule // move_return_rotate_exec_tb
